/* File: include/scc_pkg.sv */
// Constants and types shared by the serial controller register access block
//==============================================================
//==============================================================
package scc_pkg;
	// Widths
	localparam int DATA_W = 8;
	localparam int NUM_REGS = 16;
	localparam int IDX_W = 4;
	localparam int PTR_W = 3;
	localparam int NUM_CHAN = 2;
	// Host address bits
	localparam int ADDR_W = 2;
	localparam int ADDR_CD_BIT = 0;
	localparam int ADDR_CHAN_BIT = 1;
	// Primary command register fields
	localparam int PTR_LSB = 0;
	localparam int CMD_LSB = 3;
	localparam logic [2:0] CMD_HIGH_PTR = 3'h1;
	localparam logic [2:0] CMD_CHAN_RESET = 3'h3;
	// Register indices
	localparam logic [IDX_W-1:0] IDX_PRIMARY = 4'h0;
	localparam logic [IDX_W-1:0] IDX_MODE = 4'h2;
	localparam logic [IDX_W-1:0] IDX_PROTO = 4'h4;
	localparam logic [IDX_W-1:0] IDX_SR_B_ONLY = 4'h2;
	localparam logic [IDX_W-1:0] IDX_SR_A_ONLY = 4'h4;
	localparam logic [IDX_W-1:0] IDX_SR_NONE_LO = 4'h5;
	localparam logic [IDX_W-1:0] IDX_SR_NONE_HI = 4'h7;
	localparam logic [IDX_W-1:0] IDX_PAIR_LO = 4'h8;
	localparam logic [IDX_W-1:0] IDX_PAIR_HI = 4'h9;
	localparam logic [IDX_W-1:0] IDX_BAUD_LOAD = 4'hc;
	// Baud load control bits
	localparam int BAUD_TX_BIT = 0;
	localparam int BAUD_RX_BIT = 1;
	// Reset values
	localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
	localparam logic [IDX_W-1:0] PTR_RST = 4'h0;
	localparam logic [15:0] BAUD_RST = 16'h0000;
	// Pointer state
	typedef enum logic [0:0]
	{
		PTR_IDLE = 1'b0,
		PTR_ARMED = 1'b1
	} scc_ptr_e;
endpackage

/* File: include/scc_ptr_if.sv */
// Carrier between the register bank and one channel's pointer unit
interface scc_ptr_if;
	logic acc_wr; // Control location write for this channel
	logic acc_rd; // Control location read for this channel
	logic [scc_pkg::DATA_W-1:0] wdata; // Host write byte
	logic [scc_pkg::IDX_W-1:0] idx; // Register selected now
	logic armed; // A pointer value is pending
	modport bank (output acc_wr, output acc_rd, output wdata, input idx, input armed);
	modport ptr (input acc_wr, input acc_rd, input wdata, output idx, output armed);
endinterface

/* File: src/scc_ptr_unit.sv */
// Per-channel register pointer with high pointer and auto clear
module scc_ptr_unit
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce,
	scc_ptr_if.ptr pif
);
	//==============================================================
	// Pointer state
	//==============================================================
	scc_pkg::scc_ptr_e state_r; // Idle or pending pointer
	logic [scc_pkg::IDX_W-1:0] ptr_r; // Held register index
	logic [2:0] cmd; // Command field of the written byte
	logic [scc_pkg::PTR_W-1:0] wlo; // Pointer field of the written byte

	assign cmd = pif.wdata[scc_pkg::CMD_LSB +: 3];
	assign wlo = pif.wdata[scc_pkg::PTR_LSB +: scc_pkg::PTR_W];
	assign pif.idx = ptr_r;
	assign pif.armed = (state_r == scc_pkg::PTR_ARMED);

	// Arm on a primary write naming a register, clear after the next access
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r <= scc_pkg::PTR_IDLE;
			ptr_r <= scc_pkg::PTR_RST;
		end
		else if (ce && (pif.acc_wr || pif.acc_rd))
		begin
			case (state_r)
				scc_pkg::PTR_IDLE:
				begin
					// Channel reset command leaves the pointer cleared
					if (pif.acc_wr && cmd != scc_pkg::CMD_CHAN_RESET &&
						(wlo != 3'h0 || cmd == scc_pkg::CMD_HIGH_PTR))
					begin
						state_r <= scc_pkg::PTR_ARMED;
						ptr_r <= {cmd == scc_pkg::CMD_HIGH_PTR, wlo};
					end
				end
				scc_pkg::PTR_ARMED:
				begin
					state_r <= scc_pkg::PTR_IDLE;
					ptr_r <= scc_pkg::PTR_RST;
				end
				default:
				begin
					state_r <= scc_pkg::PTR_IDLE;
					ptr_r <= scc_pkg::PTR_RST;
				end
			endcase
		end
	end

	//==============================================================
	// Checks
	//==============================================================
	property p_autoclear;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && (pif.acc_wr || pif.acc_rd) && pif.armed) |=> (!pif.armed && pif.idx == 4'h0);
	endproperty
	a_autoclear: assert property (p_autoclear)
		else $error("Pointer not cleared after access");

	property p_high_ptr;
		@(posedge clk_sys) disable iff (!rstn)
		(ce && pif.acc_wr && !pif.armed && cmd == scc_pkg::CMD_HIGH_PTR)
		|=> (pif.armed && pif.idx == {1'b1, $past(wlo)});
	endproperty
	a_high_ptr: assert property (p_high_ptr)
		else $error("High pointer did not select upper register");
endmodule

/* File: src/scc_regs.sv */
// Dual-channel register bank reached through data and control locations
//
// Local design decisions: the register addresses and the strobed register port.
module scc_regs
(
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic ce, // Freezes all state while low
	input wire logic [scc_pkg::ADDR_W-1:0] addr, // Bit 0 control/data, bit 1 channel B
	input wire logic [scc_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [scc_pkg::DATA_W-1:0] rdata,
	input wire logic [scc_pkg::NUM_REGS*scc_pkg::DATA_W-1:0] stat_a,
	input wire logic [scc_pkg::NUM_REGS*scc_pkg::DATA_W-1:0] stat_b,
	input wire logic [scc_pkg::DATA_W-1:0] rx_data_a,
	input wire logic [scc_pkg::DATA_W-1:0] rx_data_b,
	output logic rx_take_a,
	output logic rx_take_b,
	output logic [scc_pkg::DATA_W-1:0] tx_data_a,
	output logic [scc_pkg::DATA_W-1:0] tx_data_b,
	output logic tx_load_a,
	output logic tx_load_b,
	output logic [scc_pkg::NUM_REGS*scc_pkg::DATA_W-1:0] ctrl_a,
	output logic [scc_pkg::NUM_REGS*scc_pkg::DATA_W-1:0] ctrl_b,
	output logic [scc_pkg::DATA_W-1:0] interface_mode_reg_chan_a,
	output logic [scc_pkg::DATA_W-1:0] interface_mode_reg_chan_b,
	output logic [15:0] paired_ctrl_eight_nine_a,
	output logic [15:0] paired_ctrl_eight_nine_b,
	output logic [15:0] baud_tx_count_a,
	output logic [15:0] baud_tx_count_b,
	output logic [15:0] baud_rx_count_a,
	output logic [15:0] baud_rx_count_b,
	output logic chan_reset_a,
	output logic chan_reset_b
);
	//==============================================================
	// Helpers
	//==============================================================
	// Pick one byte from a flattened register set
	function automatic logic [7:0] pick_byte
	(
		input logic [scc_pkg::NUM_REGS*scc_pkg::DATA_W-1:0] v,
		input logic [scc_pkg::IDX_W-1:0] i
	);
		pick_byte = v[i*scc_pkg::DATA_W +: scc_pkg::DATA_W];
	endfunction

	// Status registers missing on a channel read as zero
	function automatic logic sr_present
	(
		input logic ch,
		input logic [scc_pkg::IDX_W-1:0] i
	);
		sr_present = 1'b1;
		if (i >= scc_pkg::IDX_SR_NONE_LO && i <= scc_pkg::IDX_SR_NONE_HI)
		begin
			sr_present = 1'b0;
		end
		else if (i == scc_pkg::IDX_SR_B_ONLY && !ch)
		begin
			sr_present = 1'b0;
		end
		else if (i == scc_pkg::IDX_SR_A_ONLY && ch)
		begin
			sr_present = 1'b0;
		end
	endfunction

	//==============================================================
	// Address decode
	//==============================================================
	logic cd; // High for the control location
	logic chan; // High for channel B
	logic [scc_pkg::IDX_W-1:0] idx_c [scc_pkg::NUM_CHAN]; // Pointer of each channel
	logic armed_c [scc_pkg::NUM_CHAN]; // Pending pointer of each channel
	logic [scc_pkg::IDX_W-1:0] sel_idx; // Register chosen on the selected channel
	logic sel_armed; // Selected channel has a pending pointer
	logic [2:0] wcmd; // Command field of the write byte
	logic ctl_wr; // Control location write
	logic ctl_rd; // Control location read
	logic dat_wr; // Data location write
	logic dat_rd; // Data location read

	assign cd = addr[scc_pkg::ADDR_CD_BIT];
	assign chan = addr[scc_pkg::ADDR_CHAN_BIT];
	assign sel_idx = idx_c[chan];
	assign sel_armed = armed_c[chan];
	assign wcmd = wdata[scc_pkg::CMD_LSB +: 3];
	assign ctl_wr = ce && wr && cd;
	assign ctl_rd = ce && rd && cd;
	assign dat_wr = ce && wr && !cd;
	assign dat_rd = ce && rd && !cd;

	//==============================================================
	// Pointer units, one per channel
	//==============================================================
	for (genvar c = 0; c < scc_pkg::NUM_CHAN; c++)
	begin : g_ch
		scc_ptr_if pif ();
		assign pif.acc_wr = wr && cd && (chan == 1'(c));
		assign pif.acc_rd = rd && cd && (chan == 1'(c));
		assign pif.wdata = wdata;
		assign idx_c[c] = pif.idx;
		assign armed_c[c] = pif.armed;
		scc_ptr_unit u_ptr
		(
			.clk_sys(clk_sys),
			.rstn(rstn),
			.ce(ce),
			.pif(pif)
		);
	end

	//==============================================================
	// Control register storage
	//==============================================================
	logic [scc_pkg::DATA_W-1:0] ctrl_mem [scc_pkg::NUM_CHAN][scc_pkg::NUM_REGS]; // Per channel
	logic do_reset; // Channel reset command on a primary write

	assign do_reset = ctl_wr && !sel_armed && wcmd == scc_pkg::CMD_CHAN_RESET;

	// Store control writes, channel reset clears the channel's set
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int c = 0; c < scc_pkg::NUM_CHAN; c++)
			begin
				for (int r = 0; r < scc_pkg::NUM_REGS; r++)
				begin
					ctrl_mem[c][r] <= scc_pkg::CTRL_RST;
				end
			end
		end
		else if (do_reset)
		begin
			for (int r = 0; r < scc_pkg::NUM_REGS; r++)
			begin
				ctrl_mem[chan][r] <= scc_pkg::CTRL_RST;
			end
		end
		else if (ctl_wr)
		begin
			// Pointer zero selects the primary command register
			ctrl_mem[chan][sel_idx] <= wdata;
		end
	end

	// Channel reset pulse towards the channel logic
	assign chan_reset_a = do_reset && !chan;
	assign chan_reset_b = do_reset && chan;

	//==============================================================
	// Register pair and baud count loading
	//==============================================================
	logic [15:0] pair_c [scc_pkg::NUM_CHAN]; // Registers eight and nine together
	logic [15:0] sel_pair; // Pair of the selected channel
	logic [15:0] baud_tx_r [scc_pkg::NUM_CHAN]; // Loaded transmit count
	logic [15:0] baud_rx_r [scc_pkg::NUM_CHAN]; // Loaded receive count
	logic baud_wr; // Write to the baud load register

	for (genvar c = 0; c < scc_pkg::NUM_CHAN; c++)
	begin : g_pair
		assign pair_c[c] = {ctrl_mem[c][scc_pkg::IDX_PAIR_HI], ctrl_mem[c][scc_pkg::IDX_PAIR_LO]};
	end
	assign sel_pair = pair_c[chan];
	assign baud_wr = ctl_wr && sel_armed && sel_idx == scc_pkg::IDX_BAUD_LOAD;

	// Load the count from the pair when the matching bit is written set
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int c = 0; c < scc_pkg::NUM_CHAN; c++)
			begin
				baud_tx_r[c] <= scc_pkg::BAUD_RST;
				baud_rx_r[c] <= scc_pkg::BAUD_RST;
			end
		end
		else if (baud_wr)
		begin
			if (wdata[scc_pkg::BAUD_TX_BIT])
			begin
				baud_tx_r[chan] <= sel_pair;
			end
			if (wdata[scc_pkg::BAUD_RX_BIT])
			begin
				baud_rx_r[chan] <= sel_pair;
			end
		end
	end

	//==============================================================
	// Data path
	//==============================================================
	logic [scc_pkg::DATA_W-1:0] tx_r [scc_pkg::NUM_CHAN]; // Transmit data register

	// Data writes bypass the pointer
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int c = 0; c < scc_pkg::NUM_CHAN; c++)
			begin
				tx_r[c] <= scc_pkg::CTRL_RST;
			end
		end
		else if (dat_wr)
		begin
			tx_r[chan] <= wdata;
		end
	end

	// Strobes to the channel data logic
	assign tx_load_a = dat_wr && !chan;
	assign tx_load_b = dat_wr && chan;
	assign rx_take_a = dat_rd && !chan;
	assign rx_take_b = dat_rd && chan;

	//==============================================================
	// Read data
	//==============================================================
	logic [scc_pkg::DATA_W-1:0] stat_sel; // Status byte of the selected register
	logic [scc_pkg::DATA_W-1:0] rx_sel; // Receive byte of the selected channel
	logic [scc_pkg::DATA_W-1:0] rdata_r; // Registered read data

	// Selected pointer is zero when idle, giving the primary status
	always_comb
	begin
		stat_sel = 8'h00;
		if (sr_present(chan, sel_idx))
		begin
			stat_sel = chan ? pick_byte(stat_b, sel_idx) : pick_byte(stat_a, sel_idx);
		end
	end
	assign rx_sel = chan ? rx_data_b : rx_data_a;

	// Read data stands in the cycle after the strobe, then clears unless ce is low
	always_ff @(posedge clk_sys or negedge rstn)
	begin
		if (!rstn)
		begin
			rdata_r <= 8'h00;
		end
		else if (ce)
		begin
			if (ctl_rd)
			begin
				rdata_r <= stat_sel;
			end
			else if (dat_rd)
			begin
				rdata_r <= rx_sel;
			end
			else
			begin
				rdata_r <= 8'h00;
			end
		end
	end
	assign rdata = rdata_r;

	//==============================================================
	// Output mapping
	//==============================================================
	for (genvar r = 0; r < scc_pkg::NUM_REGS; r++)
	begin : g_out
		assign ctrl_a[r*scc_pkg::DATA_W +: scc_pkg::DATA_W] = ctrl_mem[0][r];
		assign ctrl_b[r*scc_pkg::DATA_W +: scc_pkg::DATA_W] = ctrl_mem[1][r];
	end
	assign interface_mode_reg_chan_a = ctrl_mem[0][scc_pkg::IDX_MODE];
	assign interface_mode_reg_chan_b = ctrl_mem[1][scc_pkg::IDX_MODE];
	assign paired_ctrl_eight_nine_a = pair_c[0];
	assign paired_ctrl_eight_nine_b = pair_c[1];
	assign baud_tx_count_a = baud_tx_r[0];
	assign baud_tx_count_b = baud_tx_r[1];
	assign baud_rx_count_a = baud_rx_r[0];
	assign baud_rx_count_b = baud_rx_r[1];
	assign tx_data_a = tx_r[0];
	assign tx_data_b = tx_r[1];

	//==============================================================
	// Checks
	//==============================================================
	property p_status_read;
		@(posedge clk_sys) disable iff (!rstn)
		ctl_rd |=> (rdata == $past(stat_sel));
	endproperty
	a_status_read: assert property (p_status_read)
		else $error("Control read returned wrong status byte");

	property p_ptr_then_read;
		@(posedge clk_sys) disable iff (!rstn)
		(ctl_wr && !sel_armed && wcmd == 3'h0 && wdata[2:0] == 3'h3 && !chan)
		##[1:2] (ctl_rd && !chan && sel_armed) |=> (rdata == stat_a[31:24]);
	endproperty
	a_ptr_then_read: assert property (p_ptr_then_read)
		else $error("Pointer write then read missed register three");

	property p_data_read;
		@(posedge clk_sys) disable iff (!rstn)
		dat_rd |=> (rdata == $past(rx_sel));
	endproperty
	a_data_read: assert property (p_data_read)
		else $error("Data read returned wrong byte");

	property p_data_keeps_ptr;
		@(posedge clk_sys) disable iff (!rstn)
		(dat_wr || dat_rd) |=> (idx_c[$past(chan)] == $past(sel_idx));
	endproperty
	a_data_keeps_ptr: assert property (p_data_keeps_ptr)
		else $error("Data access moved the pointer");

	property p_ctrl_store;
		@(posedge clk_sys) disable iff (!rstn)
		(ctl_wr && sel_armed) |=> (ctrl_mem[$past(chan)][$past(sel_idx)] == $past(wdata));
	endproperty
	a_ctrl_store: assert property (p_ctrl_store)
		else $error("Pointed control write not stored");

	property p_primary_direct;
		@(posedge clk_sys) disable iff (!rstn)
		(ctl_wr && !sel_armed && wcmd != scc_pkg::CMD_CHAN_RESET)
		|=> (ctrl_mem[$past(chan)][0] == $past(wdata));
	endproperty
	a_primary_direct: assert property (p_primary_direct)
		else $error("Direct write missed primary command register");

	property p_mode_split;
		@(posedge clk_sys) disable iff (!rstn)
		(ctl_wr && !chan && sel_idx == scc_pkg::IDX_MODE) |=> $stable(interface_mode_reg_chan_b);
	endproperty
	a_mode_split: assert property (p_mode_split)
		else $error("Channel A mode write changed channel B");

	property p_baud_tx;
		@(posedge clk_sys) disable iff (!rstn)
		(baud_wr && wdata[scc_pkg::BAUD_TX_BIT]) |=> (baud_tx_r[$past(chan)] == $past(sel_pair));
	endproperty
	a_baud_tx: assert property (p_baud_tx)
		else $error("Transmit count not loaded from pair");

	property p_absent_sr;
		@(posedge clk_sys) disable iff (!rstn)
		(ctl_rd && !chan && sel_idx == scc_pkg::IDX_SR_B_ONLY) |=> (rdata == 8'h00);
	endproperty
	a_absent_sr: assert property (p_absent_sr)
		else $error("Missing status register did not read zero");
endmodule

/* File: tb/scc_host_model.sv */
// Host CPU model that drives the register bus of the serial controller
module scc_host_model
(
	input wire logic clk_sys,
	input wire logic [scc_pkg::DATA_W-1:0] rdata,
	output logic [scc_pkg::ADDR_W-1:0] addr,
	output logic [scc_pkg::DATA_W-1:0] wdata,
	output logic wr,
	output logic rd
);
	timeunit 1ns;
	timeprecision 1ns;
	//==============================================================
	// Bus idle state
	//==============================================================
	// Quiet bus from time zero
	initial
	begin
		addr = 2'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	//==============================================================
	// Bus cycles
	//==============================================================
	// One write cycle; the byte is inverted afterwards so stale data never looks valid
	task automatic bus_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		wdata <= ~d;
		#1;
	endtask
	// One read cycle; the byte is taken in the cycle after the strobe
	task automatic bus_rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask
	// Register number first, then the value, both at the control location
	task automatic reg_wr(input logic ch, input logic [3:0] idx, input logic [7:0] v);
		bus_wr({ch, 1'b1}, {2'h0, idx[3] ? 3'h1 : 3'h0, idx[2:0]});
		bus_wr({ch, 1'b1}, v);
	endtask
	// Register number written, then the next control read returns it
	task automatic reg_rd(input logic ch, input logic [3:0] idx, output logic [7:0] d);
		bus_wr({ch, 1'b1}, {2'h0, idx[3] ? 3'h1 : 3'h0, idx[2:0]});
		bus_rd({ch, 1'b1}, d);
	endtask
	// Channel reset, settle time, then interface mode and protocol type
	task automatic init_chan(input logic ch, input logic [7:0] mode, input logic [7:0] proto);
		bus_wr({ch, 1'b1}, 8'h18);
		repeat (3) @(posedge clk_sys);
		reg_wr(ch, 4'h2, mode);
		reg_wr(ch, 4'h4, proto);
	endtask
endmodule

/* File: tb/testbench.sv */
// Self-checking testbench of the serial controller register access block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	//==============================================================
	// Signals
	//==============================================================
	logic clk_sys = 1'b0; // 25 MHz system clock
	logic rstn = 1'b0; // Active-low reset
	logic [1:0] addr;
	logic [7:0] wdata, rdata, rx_data_a, rx_data_b, tx_data_a, tx_data_b;
	logic wr, rd;
	logic [127:0] stat_a, stat_b, ctrl_a, ctrl_b;
	logic [7:0] mode_a, mode_b;
	logic [15:0] pair_a, pair_b, btx_a, btx_b, brx_a, brx_b;
	int n_mismatch = 0; // Mismatches seen
	int compares = 0; // Comparisons made
	logic ce = 1'b1; // Clock enable, dropped by the freeze scenario
	logic tx_load_a, tx_load_b, rx_take_a, rx_take_b, rst_a, rst_b; // Strobes out
	int n_txa = 0, n_txb = 0, n_rxa = 0, n_rxb = 0, n_rsa = 0, n_rsb = 0; // Strobe counts
	logic [7:0] d; // Read byte
	//==============================================================
	// Clock, reset and fixed inputs
	//==============================================================
	// Half period of 20 ns
	always #20 clk_sys = ~clk_sys;
	// Status patterns: channel A bytes a0+i, channel B bytes b0+i
	initial
	begin
		for (int i = 0; i < 16; i++)
		begin
			stat_a[8*i+:8] = 8'ha0 + 8'(i);
			stat_b[8*i+:8] = 8'hb0 + 8'(i);
		end
		rx_data_a = 8'h5e;
		rx_data_b = 8'he5;
	end
	// Count the one-cycle strobes while they stand
	always @(posedge clk_sys)
	begin
		n_txa <= n_txa + int'(tx_load_a);
		n_txb <= n_txb + int'(tx_load_b);
		n_rxa <= n_rxa + int'(rx_take_a);
		n_rxb <= n_rxb + int'(rx_take_b);
		n_rsa <= n_rsa + int'(rst_a);
		n_rsb <= n_rsb + int'(rst_b);
	end
	//==============================================================
	// Instances
	//==============================================================
	scc_regs scc_regs_i (.clk_sys(clk_sys), .rstn(rstn), .ce(ce), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .stat_a(stat_a), .stat_b(stat_b),
		.rx_data_a(rx_data_a), .rx_data_b(rx_data_b), .rx_take_a(rx_take_a),
		.rx_take_b(rx_take_b), .tx_data_a(tx_data_a), .tx_data_b(tx_data_b),
		.tx_load_a(tx_load_a), .tx_load_b(tx_load_b),
		.ctrl_a(ctrl_a), .ctrl_b(ctrl_b), .interface_mode_reg_chan_a(mode_a),
		.interface_mode_reg_chan_b(mode_b), .paired_ctrl_eight_nine_a(pair_a),
		.paired_ctrl_eight_nine_b(pair_b), .baud_tx_count_a(btx_a), .baud_tx_count_b(btx_b),
		.baud_rx_count_a(brx_a), .baud_rx_count_b(brx_b), .chan_reset_a(rst_a),
		.chan_reset_b(rst_b));
	scc_host_model scc_host_model_i (.clk_sys(clk_sys), .rdata(rdata), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd));
	//==============================================================
	// Checking helpers
	//==============================================================
	// Byte i of a register vector, zero extended
	function automatic logic [15:0] byt(input logic [127:0] v, input int i);
		return {8'h00, v[8*i+:8]};
	endfunction
	// Compare and count
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Counts and verdict
	task automatic conclude;
		$display("Counts: compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	//==============================================================
	// Scenarios
	//==============================================================
	// Cleared state after reset
	task automatic t_reset;
		chk("rdata", {8'h00, rdata}, 16'h0000);
		chk("ctrl_a low", ctrl_a[15:0], 16'h0000);
		chk("baud_tx_a", btx_a, 16'h0000);
		$display("test reset done");
	endtask
	// Init order on both channels, per-channel interface mode
	task automatic t_init;
		scc_host_model_i.init_chan(1'b0, 8'h5a, 8'h44);
		scc_host_model_i.init_chan(1'b1, 8'ha5, 8'h4c);
		chk("mode_a", {8'h00, mode_a}, 16'h005a);
		chk("mode_b", {8'h00, mode_b}, 16'h00a5);
		chk("proto_a", byt(ctrl_a, 4), 16'h0044);
		chk("proto_b", byt(ctrl_b, 4), 16'h004c);
		scc_host_model_i.bus_wr(2'b01, 8'h18);
		repeat (3) @(posedge clk_sys);
		chk("mode_a cleared", byt(ctrl_a, 2), 16'h0000);
		chk("mode_b kept", byt(ctrl_b, 2), 16'h00a5);
		$display("test init done");
	endtask
	// Every pointed register on channel B, low and high pointer
	task automatic t_regs;
		for (int i = 1; i < 16; i++)
			scc_host_model_i.reg_wr(1'b1, 4'(i), 8'hc0 + 8'(i));
		for (int i = 1; i < 16; i++)
			chk("ctrl_b byte", byt(ctrl_b, i), 16'h00c0 + 16'(i));
		scc_host_model_i.bus_wr(2'b11, 8'h40);
		chk("primary_b", byt(ctrl_b, 0), 16'h0040);
		chk("ctrl_b one kept", byt(ctrl_b, 1), 16'h00c1);
		chk("pair_b", pair_b, 16'hc9c8);
		$display("test regs done");
	endtask
	// Status reads: pointed, high, direct, absent
	task automatic t_stat;
		scc_host_model_i.reg_rd(1'b1, 4'h3, d);
		chk("sr3_b", {8'h00, d}, 16'h00b3);
		@(posedge clk_sys);
		#1;
		chk("rdata idle", {8'h00, rdata}, 16'h0000);
		scc_host_model_i.reg_rd(1'b1, 4'hb, d);
		chk("sr11_b", {8'h00, d}, 16'h00bb);
		scc_host_model_i.bus_rd(2'b11, d);
		chk("sr0_b", {8'h00, d}, 16'h00b0);
		scc_host_model_i.reg_rd(1'b0, 4'h3, d);
		chk("sr3_a", {8'h00, d}, 16'h00a3);
		scc_host_model_i.reg_rd(1'b0, 4'h4, d);
		chk("sr4_a", {8'h00, d}, 16'h00a4);
		scc_host_model_i.reg_rd(1'b0, 4'h2, d);
		chk("sr2_a absent", {8'h00, d}, 16'h0000);
		scc_host_model_i.reg_rd(1'b1, 4'h4, d);
		chk("sr4_b absent", {8'h00, d}, 16'h0000);
		scc_host_model_i.reg_rd(1'b0, 4'h6, d);
		chk("sr6_a absent", {8'h00, d}, 16'h0000);
		scc_host_model_i.bus_rd(2'b01, d);
		chk("sr0_a", {8'h00, d}, 16'h00a0);
		$display("test status done");
	endtask
	// Register pair and baud count loading
	task automatic t_baud;
		scc_host_model_i.reg_wr(1'b0, 4'h8, 8'h34);
		scc_host_model_i.reg_wr(1'b0, 4'h9, 8'h12);
		scc_host_model_i.reg_wr(1'b0, 4'hc, 8'h03);
		chk("pair_a", pair_a, 16'h1234);
		chk("btx_a", btx_a, 16'h1234);
		chk("brx_a", brx_a, 16'h1234);
		scc_host_model_i.reg_wr(1'b0, 4'h8, 8'h78);
		scc_host_model_i.reg_wr(1'b0, 4'hc, 8'h01);
		chk("btx_a tx only", btx_a, 16'h1278);
		chk("brx_a kept", brx_a, 16'h1234);
		chk("btx_b", btx_b, 16'h0000);
		chk("brx_b", brx_b, 16'h0000);
		$display("test baud done");
	endtask
	// Data path leaves pointer alone; pointers per channel
	task automatic t_data;
		scc_host_model_i.bus_wr(2'b01, 8'h05);
		scc_host_model_i.bus_wr(2'b00, 8'h3c);
		chk("tx_data_a", {8'h00, tx_data_a}, 16'h003c);
		scc_host_model_i.bus_rd(2'b10, d);
		chk("rx_b", {8'h00, d}, 16'h00e5);
		scc_host_model_i.bus_wr(2'b10, 8'hc3);
		chk("tx_data_b", {8'h00, tx_data_b}, 16'h00c3);
		scc_host_model_i.bus_rd(2'b00, d);
		chk("rx_a", {8'h00, d}, 16'h005e);
		scc_host_model_i.bus_wr(2'b01, 8'h99);
		chk("ctrl_a5", byt(ctrl_a, 5), 16'h0099);
		scc_host_model_i.bus_wr(2'b01, 8'h06);
		scc_host_model_i.bus_wr(2'b11, 8'h40);
		scc_host_model_i.bus_wr(2'b01, 8'h66);
		chk("ctrl_a6", byt(ctrl_a, 6), 16'h0066);
		chk("ctrl_b6", byt(ctrl_b, 6), 16'h00c6);
		chk("primary_b", byt(ctrl_b, 0), 16'h0040);
		$display("test data done");
	endtask
	// Clock enable low freezes registers, pointer and strobes
	task automatic t_freeze;
		@(posedge clk_sys);
		ce <= 1'b0;
		scc_host_model_i.bus_wr(2'b01, 8'h18);
		scc_host_model_i.bus_wr(2'b00, 8'h11);
		scc_host_model_i.bus_wr(2'b01, 8'h05);
		@(posedge clk_sys);
		ce <= 1'b1;
		chk("ctrl_a5 frozen", byt(ctrl_a, 5), 16'h0099);
		chk("primary_a frozen", byt(ctrl_a, 0), 16'h0006);
		chk("tx_data_a frozen", {8'h00, tx_data_a}, 16'h003c);
		scc_host_model_i.bus_rd(2'b01, d);
		chk("sr0_a after freeze", {8'h00, d}, 16'h00a0);
		chk("tx_load_a count", 16'(n_txa), 16'h0001);
		chk("tx_load_b count", 16'(n_txb), 16'h0001);
		chk("rx_take_a count", 16'(n_rxa), 16'h0001);
		chk("rx_take_b count", 16'(n_rxb), 16'h0001);
		chk("chan_reset_a count", 16'(n_rsa), 16'h0002);
		chk("chan_reset_b count", 16'(n_rsb), 16'h0001);
		$display("test freeze done");
	endtask
	//==============================================================
	// Main sequence and watchdog
	//==============================================================
	// Reset for 8 cycles, then the scenarios
	initial
	begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		#1;
		t_reset();
		t_init();
		t_regs();
		t_stat();
		t_baud();
		t_data();
		t_freeze();
		conclude();
	end
	// Bounded run length
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		n_mismatch++;
		conclude();
	end
endmodule
